// ===== src/erw_ctrl.sv
// How it works
// - The ready level is selectable per cycle, so either a high or a low pin level means ready.
// - In synchronous mode the raw pin is judged directly, and the far side moves it with the system clock.
// - In asynchronous mode the pin goes through two flops and every ready cycle gets at least one waitstate.
// - The first sample point falls after the programmed command, setup and access phases.
// - A ready found inactive adds one ready waitstate phase and ready is sampled again.
// - A ready found active ends the access and moves on to the hold phase, or straight to idle when hold_len is zero.
// - The asynchronous sample point lies at least one cycle later than the synchronous one.
// - Ready is ignored until the programmed access waitstates have run out.
// - Read data is latched on the edge that raises the read strobe.
`timescale 1ns/100ps
`include "erw_params.svh"
`default_nettype none

module erw_ctrl (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     cycle_start,
    input  wire logic                     cycle_write,
    input  wire logic [`ERW_CMD_W-1:0]    cfg_cmd_len,
    input  wire logic                     cfg_wsetup_en,
    input  wire logic [`ERW_ACC_W-1:0]    cfg_access_m1,
    input  wire logic [`ERW_HOLD_W-1:0]   cfg_hold_len,
    input  wire logic                     cfg_ready_en,
    input  wire logic                     cfg_ready_async,
    input  wire logic                     cfg_ready_pol,
    input  wire logic                     ready_pin,
    input  wire logic [`ERW_DATA_W-1:0]   rd_data_pin,
    output logic                          bus_reference_clock_out,
    output logic                          busy,
    output logic                          rd_strobe_n,
    output logic                          wr_strobe_n,
    output logic                          ready_waitstate_phase,
    output logic                          cycle_done,
    output logic [`ERW_DATA_W-1:0]        rd_data
);

    // ****************************************************************
    // Latched cycle configuration
    // ****************************************************************
    logic                      is_write;
    logic [`ERW_CMD_W-1:0]     cmd_len;
    logic                      wsetup_en;
    logic [`ERW_ACC_W-1:0]     access_m1;
    logic [`ERW_HOLD_W-1:0]    hold_len;
    logic                      rdy_en;
    logic                      rdy_async;
    logic                      rdy_pol;
    erw_pkg::erw_phase_e       phase;
    erw_pkg::erw_phase_e       next_phase;
    erw_pkg::erw_cnt_t         cnt;
    erw_pkg::erw_cnt_t         next_cnt;
    logic                      sync1;
    logic                      sync2;
    logic                      rdy_seen;
    logic                      leave_access;

    function automatic logic is_ready(input logic level, input logic pol);
        is_ready = (level == pol);
    endfunction : is_ready

    function automatic logic next_is_write();
        next_is_write = (phase == erw_pkg::ERW_IDLE) ? cycle_write : is_write;
    endfunction : next_is_write

    always_ff @(posedge clk) begin
        if (rst) begin
            is_write  <= `ERW_CFG_RST;
            cmd_len   <= '0;
            wsetup_en <= `ERW_CFG_RST;
            access_m1 <= '0;
            hold_len  <= '0;
            rdy_en    <= `ERW_CFG_RST;
            rdy_async <= `ERW_CFG_RST;
            rdy_pol   <= `ERW_CFG_RST;
        end else if (phase == erw_pkg::ERW_IDLE && cycle_start) begin
            is_write  <= cycle_write;
            cmd_len   <= cfg_cmd_len;
            wsetup_en <= cfg_wsetup_en;
            access_m1 <= cfg_access_m1;
            hold_len  <= cfg_hold_len;
            rdy_en    <= cfg_ready_en;
            rdy_async <= cfg_ready_async;
            rdy_pol   <= cfg_ready_pol;
        end
    end

    // ****************************************************************
    // Ready synchroniser
    // ****************************************************************
    // Two flops cost latency but make an unrelated ready edge safe to use.
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= ready_pin;
            sync2 <= sync1;
        end
    end

    // The asynchronous path only looks at the second flop, hence later.
    always_comb begin
        if (rdy_async) begin
            rdy_seen = is_ready(sync2, rdy_pol);
        end else begin
            rdy_seen = is_ready(ready_pin, rdy_pol);
        end
    end

    // ****************************************************************
    // Phase sequencer
    // ****************************************************************
    // The first sample point follows the programmed phases on its own.
    always_comb begin
        next_phase   = phase;
        next_cnt     = cnt;
        leave_access = 1'b0;
        case (phase)
            erw_pkg::ERW_IDLE: begin
                if (cycle_start) begin
                    if (cfg_cmd_len != '0) begin
                        next_phase = erw_pkg::ERW_CMD;
                        next_cnt   = 5'(cfg_cmd_len - 2'h1);
                    end else if (cfg_wsetup_en && cycle_write) begin
                        next_phase = erw_pkg::ERW_WSETUP;
                        next_cnt   = `ERW_CNT_ZERO;
                    end else begin
                        next_phase = erw_pkg::ERW_ACCESS;
                        next_cnt   = cfg_access_m1;
                    end
                end
            end
            erw_pkg::ERW_CMD: begin
                if (cnt != `ERW_CNT_ZERO) begin
                    next_cnt = 5'(cnt - 5'h01);
                end else if (wsetup_en && is_write) begin
                    next_phase = erw_pkg::ERW_WSETUP;
                end else begin
                    next_phase = erw_pkg::ERW_ACCESS;
                    next_cnt   = access_m1;
                end
            end
            erw_pkg::ERW_WSETUP: begin
                next_phase = erw_pkg::ERW_ACCESS;
                next_cnt   = access_m1;
            end
            erw_pkg::ERW_ACCESS: begin
                if (cnt != `ERW_CNT_ZERO) begin
                    next_cnt = 5'(cnt - 5'h01);
                end else if (!rdy_en || (!rdy_async && rdy_seen)) begin
                    leave_access = 1'b1;
                end else begin
                    next_phase = erw_pkg::ERW_RDY_WAIT;
                end
            end
            erw_pkg::ERW_RDY_WAIT: begin
                if (rdy_seen) begin
                    leave_access = 1'b1;
                end
            end
            erw_pkg::ERW_HOLD: begin
                if (cnt != `ERW_CNT_ZERO) begin
                    next_cnt = 5'(cnt - 5'h01);
                end else begin
                    next_phase = erw_pkg::ERW_IDLE;
                end
            end
            default: begin
                next_phase = erw_pkg::ERW_IDLE;
            end
        endcase
        if (leave_access) begin
            if (hold_len != '0) begin
                next_phase = erw_pkg::ERW_HOLD;
                next_cnt   = 5'(hold_len - 2'h1);
            end else begin
                next_phase = erw_pkg::ERW_IDLE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= erw_pkg::ERW_IDLE;
            cnt   <= `ERW_CNT_ZERO;
        end else begin
            phase <= next_phase;
            cnt   <= next_cnt;
        end
    end

    // ****************************************************************
    // Pin and status outputs
    // ****************************************************************
    // Strobes rise on the exit edge, so ready may fall right after it.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_strobe_n           <= `ERW_STROBE_IDLE;
            wr_strobe_n           <= `ERW_STROBE_IDLE;
            busy                  <= 1'b0;
            ready_waitstate_phase <= 1'b0;
            cycle_done            <= 1'b0;
        end else begin
            rd_strobe_n <= !((next_phase == erw_pkg::ERW_ACCESS ||
                              next_phase == erw_pkg::ERW_RDY_WAIT) && !next_is_write());
            wr_strobe_n <= !((next_phase == erw_pkg::ERW_ACCESS ||
                              next_phase == erw_pkg::ERW_RDY_WAIT) && next_is_write());
            busy                  <= (next_phase != erw_pkg::ERW_IDLE);
            ready_waitstate_phase <= (next_phase == erw_pkg::ERW_RDY_WAIT);
            cycle_done            <= (phase != erw_pkg::ERW_IDLE) &&
                                     (next_phase == erw_pkg::ERW_IDLE);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= `ERW_DATA_RST;
        end else if (leave_access && !is_write) begin
            rd_data <= rd_data_pin;
        end
    end

    // The reference clock runs at half the system rate, held low in reset and free-running after it.
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_reference_clock_out <= 1'b0;
        end else begin
            bus_reference_clock_out <= !bus_reference_clock_out;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pol_select: assert property (
        phase == erw_pkg::ERW_RDY_WAIT && !rdy_async && (ready_pin == rdy_pol)
        |=> phase != erw_pkg::ERW_RDY_WAIT)
        else $error("Ready at selected level did not end the wait.");

    a_sync_fast: assert property (
        phase == erw_pkg::ERW_ACCESS && cnt == 5'h00 && rdy_en && !rdy_async &&
        (ready_pin == rdy_pol) |=> !ready_waitstate_phase)
        else $error("Synchronous ready inserted a waitstate.");

    a_async_wait: assert property (
        phase == erw_pkg::ERW_ACCESS && cnt == 5'h00 && rdy_en && rdy_async
        |=> ready_waitstate_phase)
        else $error("Asynchronous ready cycle without a waitstate.");

    a_not_ready: assert property (
        phase == erw_pkg::ERW_RDY_WAIT && !rdy_seen |=> phase == erw_pkg::ERW_RDY_WAIT)
        else $error("Wait ended while ready inactive.");

    a_ready_ends: assert property (
        phase == erw_pkg::ERW_RDY_WAIT && rdy_seen |=> rd_strobe_n && wr_strobe_n)
        else $error("Strobe still active after ready seen.");

    a_async_late: assert property (
        phase == erw_pkg::ERW_RDY_WAIT && rdy_async |-> rdy_seen == ($past(ready_pin, 2) == rdy_pol))
        else $error("Asynchronous sample not from synchroniser.");

    a_access_min: assert property (
        phase == erw_pkg::ERW_ACCESS && cnt != 5'h00 |=> phase == erw_pkg::ERW_ACCESS)
        else $error("Access phase left before waitstates elapsed.");

    a_read_latch: assert property (
        $rose(rd_strobe_n) && busy |-> rd_data == $past(rd_data_pin))
        else $error("Read data not latched on strobe rise.");

    a_first_access: assert property (
        phase == erw_pkg::ERW_IDLE && cycle_start && cfg_cmd_len == 2'h0 &&
        !(cfg_wsetup_en && cycle_write) |=> phase == erw_pkg::ERW_ACCESS && cnt == $past(cfg_access_m1))
        else $error("Access phase not entered with programmed length.");

    c_sync_cycle:  cover property (phase == erw_pkg::ERW_RDY_WAIT && !rdy_async ##[1:40] !busy);
    c_async_cycle: cover property (phase == erw_pkg::ERW_RDY_WAIT && rdy_async && rdy_seen);
    c_write_cycle: cover property (phase == erw_pkg::ERW_WSETUP ##1 !wr_strobe_n);
    c_read_done:   cover property (!rd_strobe_n ##1 rd_strobe_n ##[1:8] cycle_done);

endmodule : erw_ctrl

`default_nettype wire

// ===== src/erw_params.svh
`ifndef ERW_PARAMS_SVH
`define ERW_PARAMS_SVH

// ****************************************************************
// Phase field widths and reset values
// ****************************************************************
`define ERW_CMD_W        2
`define ERW_ACC_W        5
`define ERW_HOLD_W       2
`define ERW_DATA_W       16
`define ERW_CNT_ZERO     5'h00
`define ERW_DATA_RST     16'h0000
`define ERW_CFG_RST      1'b0
`define ERW_STROBE_IDLE  1'b1

`endif

// ===== src/erw_pkg.sv
package erw_pkg;

    // ****************************************************************
    // Bus cycle phases
    // ****************************************************************
    typedef enum logic [2:0] {
        ERW_IDLE,
        ERW_CMD,
        ERW_WSETUP,
        ERW_ACCESS,
        ERW_RDY_WAIT,
        ERW_HOLD
    } erw_phase_e;

    typedef logic [4:0] erw_cnt_t;

endpackage : erw_pkg

// ===== bench/erw_ready_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Far-side peripheral that answers bus cycles with a ready level
// ****************************************************************
module erw_ready_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rd_strobe_n,
    input  wire logic        wr_strobe_n,
    input  wire logic [4:0]  delay,
    input  wire logic        pol,
    input  wire logic [15:0] data_val,
    output logic             ready_pin,
    output logic [15:0]      rd_data_pin
);
    logic       strobe_low;
    logic [4:0] low_cnt;

    assign strobe_low = !rd_strobe_n || !wr_strobe_n;

    // Counts on the clock only, so the ready level moves in step with it.
    always_ff @(posedge clk) begin
        if (rst || !strobe_low) begin
            low_cnt <= 5'h00;
        end else if (low_cnt != 5'h1f) begin
            low_cnt <= low_cnt + 5'h01;
        end
    end

    // Held until the strobe rises, which is long enough for the synchroniser.
    // It drops with the strobe, so a following cycle never sees a stale ready.
    assign ready_pin = (strobe_low && low_cnt >= delay) ? pol : !pol;

    // A released data bus shows the inverse rather than the last value.
    assign rd_data_pin = !rd_strobe_n ? data_val : ~data_val;
endmodule : erw_ready_model

`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/100ps
`include "erw_params.svh"
`default_nettype none

module tb;
    typedef struct {
        logic       w;
        logic [1:0] c;
        logic       s;
        logic [4:0] am1;
        logic [1:0] h;
        logic       en;
        logic       asy;
        logic       pol;
        logic [4:0] d;
        int         low;
        int         wt;
    } erw_row_s;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cycle_start = 1'b0;
    logic        cycle_write = 1'b0;
    logic [1:0]  cfg_cmd_len = 2'h0;
    logic        cfg_wsetup_en = 1'b0;
    logic [4:0]  cfg_access_m1 = 5'h01;
    logic [1:0]  cfg_hold_len = 2'h0;
    logic        cfg_ready_en = 1'b0;
    logic        cfg_ready_async = 1'b0;
    logic        cfg_ready_pol = 1'b1;
    logic [4:0]  delay = 5'h00;
    logic [15:0] data_val = 16'h0000;
    logic        ready_pin;
    logic [15:0] rd_data_pin;
    logic        refclk;
    logic        busy;
    logic        rd_strobe_n;
    logic        wr_strobe_n;
    logic        ready_waitstate_phase;
    logic        cycle_done;
    logic [15:0] rd_data;
    int          errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n;

    // Expected strobe and waitstate clocks are worked out by hand per row.
    erw_row_s rows[6] = '{
        '{1'b0, 2'h0, 1'b0, 5'h01, 2'h1, 1'b1, 1'b0, 1'b1, 5'h00, 2, 0},
        '{1'b0, 2'h3, 1'b0, 5'h00, 2'h0, 1'b1, 1'b0, 1'b0, 5'h03, 4, 3},
        '{1'b1, 2'h1, 1'b1, 5'h02, 2'h2, 1'b1, 1'b1, 1'b1, 5'h00, 4, 1},
        '{1'b1, 2'h2, 1'b0, 5'h1f, 2'h3, 1'b0, 1'b0, 1'b1, 5'h00, 32, 0},
        '{1'b0, 2'h0, 1'b0, 5'h01, 2'h1, 1'b1, 1'b1, 1'b0, 5'h04, 7, 5},
        '{1'b0, 2'h0, 1'b0, 5'h07, 2'h1, 1'b1, 1'b0, 1'b1, 5'h02, 8, 0}
    };

    erw_ctrl erw_ctrl_inst (.clk(clk), .rst(rst), .cycle_start(cycle_start),
        .cycle_write(cycle_write), .cfg_cmd_len(cfg_cmd_len), .cfg_wsetup_en(cfg_wsetup_en),
        .cfg_access_m1(cfg_access_m1), .cfg_hold_len(cfg_hold_len),
        .cfg_ready_en(cfg_ready_en), .cfg_ready_async(cfg_ready_async),
        .cfg_ready_pol(cfg_ready_pol), .ready_pin(ready_pin), .rd_data_pin(rd_data_pin),
        .bus_reference_clock_out(refclk), .busy(busy), .rd_strobe_n(rd_strobe_n),
        .wr_strobe_n(wr_strobe_n), .ready_waitstate_phase(ready_waitstate_phase),
        .cycle_done(cycle_done), .rd_data(rd_data));

    erw_ready_model erw_ready_model_inst (.clk(clk), .rst(rst), .rd_strobe_n(rd_strobe_n),
        .wr_strobe_n(wr_strobe_n), .delay(delay), .pol(cfg_ready_pol),
        .data_val(data_val), .ready_pin(ready_pin), .rd_data_pin(rd_data_pin));

    // ****************************************************************
    // Clock, watchdog and reporting
    // ****************************************************************
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic close_out();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // The tests need well under a thousand clocks, so this only cuts hangs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic run_row(input erw_row_s r);
        int low;
        int wt;
        int bad;
        @(posedge clk);
        cycle_write <= r.w;
        cfg_cmd_len <= r.c;
        cfg_wsetup_en <= r.s;
        cfg_access_m1 <= r.am1;
        cfg_hold_len <= r.h;
        cfg_ready_en <= r.en;
        cfg_ready_async <= r.asy;
        cfg_ready_pol <= r.pol;
        delay <= r.d;
        data_val <= {11'h000, r.am1} ^ 16'hc3a5;
        cycle_start <= 1'b1;
        @(posedge clk);
        cycle_start <= 1'b0;
        n = 0;
        low = 0;
        wt = 0;
        bad = 0;
        do begin
            @(negedge clk);
            n++;
            if ((r.w ? wr_strobe_n : rd_strobe_n) === 1'b0) low++;
            if ((r.w ? rd_strobe_n : wr_strobe_n) !== 1'b1) bad++;
            if (ready_waitstate_phase === 1'b1) wt++;
        end while (cycle_done !== 1'b1 && n < 100);
        check("done_clocks", 16'(r.c + (r.w & r.s) + r.low + r.h + 1), 16'(n));
        check("strobe_clocks", 16'(r.low), 16'(low));
        check("wait_clocks", 16'(r.wt), 16'(wt));
        check("other_strobe", 16'h0000, 16'(bad));
        check("busy_at_done", 16'h0000, {15'h0000, busy});
        if (!r.w) check("rd_data", {11'h000, r.am1} ^ 16'hc3a5, rd_data);
    endtask : run_row

    task automatic do_reset();
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("reset_idle", 16'hc001, {rd_strobe_n, wr_strobe_n, busy, cycle_done,
            ready_waitstate_phase, refclk, 10'h001});
        check("reset_rd_data", 16'h0000, rd_data);
        // The reference clock leaves reset low and must toggle on every rising edge after it.
        @(negedge clk);
        check("release_idle", 16'hc401, {rd_strobe_n, wr_strobe_n, busy, cycle_done,
            ready_waitstate_phase, refclk, 10'h001});
        @(negedge clk);
        check("refclk_toggle", 16'h0000, {15'h0000, refclk});
    endtask : do_reset

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        do_reset();
        for (int i = 0; i < 6; i++) begin
            run_row(rows[i]);
        end
        // A second start while busy must be dropped without a trace.
        run_row(rows[0]);
        @(posedge clk);
        cycle_start <= 1'b1;
        @(posedge clk);
        cycle_start <= 1'b0;
        @(posedge clk);
        cycle_start <= 1'b1;
        @(posedge clk);
        cycle_start <= 1'b0;
        n = 0;
        repeat (15) begin
            @(negedge clk);
            if (cycle_done === 1'b1) n++;
        end
        check("done_count", 16'h0001, 16'(n));
        // Reset in the middle of a long cycle must leave the bus idle.
        @(posedge clk);
        cfg_access_m1 <= 5'h1f;
        cycle_start <= 1'b1;
        @(posedge clk);
        cycle_start <= 1'b0;
        repeat (6) @(posedge clk);
        do_reset();
        run_row(rows[1]);
        close_out();
    end
endmodule : tb

`default_nettype wire
